// File: inc/dme_cfg.svh
`ifndef DME_CFG_SVH
`define DME_CFG_SVH
`define DME_SYNC_BITS 9
`define DME_BYTE_BITS 8
`define DME_START_ADDR 7'h00
`define DME_OUT_HOLD_NS 300
`define DME_CLK_MHZ 50
`define DME_OUT_HOLD_CYC ((`DME_OUT_HOLD_NS * `DME_CLK_MHZ + 999) / 1000)
`define DME_FILTER_CYC 3
`endif

// File: inc/dme_pkg.sv
package dme_pkg;
    typedef enum logic [1:0] {DME_SYNC, DME_STREAM, DME_BIDIR} dme_mode_t;
    typedef struct packed {
        logic       data_o;
        logic       data_oe_n;
    } dme_pin_t;
    typedef struct packed {
        logic [6:0] addr;
        logic       last;
    } dme_word_t;
endpackage

// File: rtl/dme_buf.sv
`timescale 1ns/1ns
// ****************************************
// two-entry buffer
// ****************************************
module dme_buf #(
    parameter int WIDTH = 8
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_en,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    typedef struct packed {
        logic [1:0][WIDTH-1:0] mem;
        logic [1:0] cnt;
    } dme_buf_st_t;
    dme_buf_st_t st_reg, st_next;
    logic push, pop;
    assign in_ready = st_reg.cnt != 2'h2;
    assign out_valid = st_reg.cnt != 2'h0;
    assign out_data = st_reg.mem[0];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_comb
    begin
        st_next = st_reg;
        if (pop)
        begin
            st_next.mem[0] = st_reg.mem[1];
        end
        if (push)
        begin
            if (st_reg.cnt == 2'h0 || (st_reg.cnt == 2'h1 && pop))
            begin
                st_next.mem[0] = in_data;
            end
            else
            begin
                st_next.mem[1] = in_data;
            end
        end
        st_next.cnt = 2'(st_reg.cnt + {1'h0, push} - {1'h0, pop});
    end
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            st_reg <= '0;
        end
        else if (clock_en)
        begin
            st_reg <= st_next;
        end
    end
endmodule

// File: rtl/dme_top.sv
`timescale 1ns/1ns
`include "dme_cfg.svh"
module dme_top
    import dme_pkg::*;
#(
    parameter int ADDR_BITS = 7
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic clock_en,
    input wire logic scl,
    input wire logic stream_clk,
    input wire logic sda_level,
    output dme_pkg::dme_pin_t sda_pin,
    output logic [ADDR_BITS-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    output logic write_enable,
    output logic bidir_mode,
    input wire logic [7:0] bidir_tx_bit,
    input wire logic bidir_tx_drive
);
    import dme_pkg::*;
    localparam int HOLD = `DME_OUT_HOLD_CYC;
    localparam int FILT = `DME_FILTER_CYC;
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [1:0] scl_sy;
        logic [1:0] vck_sy;
        logic [1:0] sda_sy;
        logic [3:0] scl_flt;
        logic scl_clean;
        logic vck_prev;
        dme_mode_t mode;
        logic [3:0] sync_cnt;
        logic [3:0] bit_idx;
        logic [ADDR_BITS-1:0] addr;
        logic [7:0] shreg;
        logic have_byte;
        logic data_o;
        logic data_oe_n;
        logic [4:0] hold_cnt;
    } dme_st_t;
    dme_st_t st_reg, st_next;
    logic scl_fall, vck_rise;
    logic buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready;
    logic [7:0] buf_out_data;
    // ****************************************
    // prefetch buffer
    // ****************************************
    dme_buf #(.WIDTH(8)) u_buf (
        .clock(clock),
        .reset(reset),
        .clock_en(clock_en),
        .in_valid(buf_in_valid),
        .in_ready(buf_in_ready),
        .in_data(mem_rdata),
        .out_valid(buf_out_valid),
        .out_ready(buf_out_ready),
        .out_data(buf_out_data)
    );
    // ****************************************
    // outputs and strobes
    // ****************************************
    assign mem_addr = st_reg.addr;
    assign bidir_mode = st_reg.mode == DME_BIDIR;
    assign write_enable = bidir_mode && st_reg.vck_sy[1];
    assign sda_pin.data_o = st_reg.data_o;
    assign sda_pin.data_oe_n = st_reg.data_oe_n;
    // only a low level that outlasted the filter counts, not a glitch that returned high
    assign scl_fall = st_reg.scl_clean && !st_reg.scl_sy[1] && st_reg.scl_flt == 4'h0;
    assign vck_rise = st_reg.vck_sy[1] && !st_reg.vck_prev;
    // prefetch while transmit-only
    assign buf_in_valid = st_reg.mode != DME_BIDIR;
    // reload shifter when previous byte finished
    assign buf_out_ready = st_reg.mode == DME_STREAM && !st_reg.have_byte;
    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        st_next = st_reg;
        st_next.scl_sy = {st_reg.scl_sy[0], scl};
        st_next.vck_sy = {st_reg.vck_sy[0], stream_clk};
        st_next.sda_sy = {st_reg.sda_sy[0], sda_level};
        st_next.vck_prev = st_reg.vck_sy[1];
        // glitch filter: level must persist FILT+1 cycles
        if (st_reg.scl_sy[1] == st_reg.scl_clean)
        begin
            st_next.scl_flt = 4'(FILT);
        end
        else if (st_reg.scl_flt == 4'h0)
        begin
            st_next.scl_clean = st_reg.scl_sy[1];
            st_next.scl_flt = 4'(FILT);
        end
        else
        begin
            st_next.scl_flt = st_reg.scl_flt - 4'h1;
        end
        if (buf_in_valid && buf_in_ready)
        begin
            st_next.addr = ADDR_BITS'(st_reg.addr + 1'h1);
        end
        if (buf_out_valid && buf_out_ready)
        begin
            st_next.shreg = buf_out_data;
            st_next.have_byte = 1'h1;
        end
        if (st_reg.hold_cnt != 5'h0)
        begin
            st_next.hold_cnt = st_reg.hold_cnt - 5'h1;
        end
        unique case (st_reg.mode)
            DME_SYNC:
            begin
                st_next.data_oe_n = 1'h1;
                if (vck_rise)
                begin
                    st_next.sync_cnt = st_reg.sync_cnt + 4'h1;
                    if (st_reg.sync_cnt == 4'(`DME_SYNC_BITS - 1))
                    begin
                        st_next.mode = DME_STREAM;
                    end
                end
            end
            DME_STREAM:
            begin
                if (vck_rise && st_reg.have_byte)
                begin
                    if (st_reg.bit_idx == 4'(`DME_BYTE_BITS))
                    begin
                        st_next.data_oe_n = 1'h1;
                        st_next.bit_idx = 4'h0;
                        st_next.have_byte = 1'h0;
                    end
                    else
                    begin
                        st_next.data_o = st_reg.shreg[7];
                        st_next.data_oe_n = st_reg.shreg[7];
                        st_next.shreg = {st_reg.shreg[6:0], 1'h0};
                        st_next.bit_idx = st_reg.bit_idx + 4'h1;
                    end
                end
            end
            DME_BIDIR:
            begin
                // hold last output until scl falling region passes
                if (scl_fall)
                begin
                    st_next.hold_cnt = 5'(HOLD);
                end
                else if (st_reg.hold_cnt == 5'h0)
                begin
                    st_next.data_o = 1'h0;
                    st_next.data_oe_n = !(bidir_tx_drive && !bidir_tx_bit[7]);
                end
            end
            default:
            begin
                // unused mode code: settle in bidirectional mode, never back to streaming
                st_next.mode = DME_BIDIR;
                st_next.data_oe_n = 1'h1;
            end
        endcase
        if (st_reg.mode != DME_BIDIR && scl_fall)
        begin
            st_next.mode = DME_BIDIR;
            st_next.data_oe_n = 1'h1;
            st_next.hold_cnt = 5'(HOLD);
        end
    end
    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            st_reg <= '0;
            st_reg.mode <= DME_SYNC;
            st_reg.scl_clean <= 1'h1;
            st_reg.scl_flt <= 4'(FILT);
            st_reg.scl_sy <= 2'h3;
            st_reg.data_o <= 1'h1;
            st_reg.data_oe_n <= 1'h1;
            st_reg.addr <= ADDR_BITS'(`DME_START_ADDR);
        end
        else if (clock_en)
        begin
            st_reg <= st_next;
        end
    end
endmodule

// File: dv/dme_chk_assertions.sv
`timescale 1ns/1ns
// ****
// mode and stream checks
// ****
module dme_chk
    import dme_pkg::*;
#(
    parameter int ADDR_BITS = 7
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic scl,
    input wire logic stream_clk,
    input wire dme_pkg::dme_pin_t sda_pin,
    input wire logic [ADDR_BITS-1:0] mem_addr,
    input wire logic write_enable,
    input wire logic bidir_mode
);
    logic [3:0] rise_reg;
    logic last_reg;
    always_ff @(posedge clock)
    begin
        last_reg <= stream_clk;
        if (reset)
            rise_reg <= 4'h0;
        else if (stream_clk && !last_reg && rise_reg != 4'hF)
            rise_reg <= rise_reg + 4'h1;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    sequence s_scl_low;
        $fell(scl) ##0 (!scl)[*8];
    endsequence
    property p_start;
        $fell(reset) |-> sda_pin.data_oe_n && !bidir_mode && mem_addr == '0;
    endproperty
    a_start: assert property (p_start) else $error("bad state after reset");
    property p_stay;
        !$fell(bidir_mode);
    endproperty
    a_stay: assert property (p_stay) else $error("left bidirectional mode");
    property p_switch;
        s_scl_low |=> bidir_mode;
    endproperty
    a_switch: assert property (p_switch) else $error("no switch on scl fall");
    property p_hold;
        bidir_mode && $fell(scl) |=> $stable(sda_pin.data_oe_n)[*8];
    endproperty
    a_hold: assert property (p_hold) else $error("output moved after scl fall");
    property p_we;
        write_enable |-> bidir_mode;
    endproperty
    a_we: assert property (p_we) else $error("write enable outside bidir");
    property p_we_on;
        stream_clk[*4] ##0 bidir_mode |-> write_enable;
    endproperty
    a_we_on: assert property (p_we_on) else $error("no write enable with clock high");
    property p_we_off;
        (!stream_clk)[*4] |-> !write_enable;
    endproperty
    a_we_off: assert property (p_we_off) else $error("write enable with clock low");
    property p_sync;
        !sda_pin.data_oe_n |-> bidir_mode || rise_reg >= 4'hA;
    endproperty
    a_sync: assert property (p_sync) else $error("line driven during sync");
    property p_addr;
        !$stable(mem_addr) |-> mem_addr == ADDR_BITS'($past(mem_addr) + 1);
    endproperty
    a_addr: assert property (p_addr) else $error("address not ascending");
endmodule
bind dme_top dme_chk #(.ADDR_BITS(ADDR_BITS)) chk_u (.clock(clock), .reset(reset), .scl(scl),
    .stream_clk(stream_clk), .sda_pin(sda_pin), .mem_addr(mem_addr), .write_enable(write_enable),
    .bidir_mode(bidir_mode));

// File: dv/dme_far.sv
`timescale 1ns/1ns
// ****
// host side: store and pulled-up line
// ****
module dme_far
    import dme_pkg::*;
(
    input wire logic [6:0] mem_addr,
    input wire dme_pkg::dme_pin_t sda_pin,
    output logic [7:0] mem_rdata,
    output logic sda_line
);
    assign mem_rdata = {1'h0, mem_addr} ^ 8'h5A;
    assign sda_line = sda_pin.data_oe_n ? 1'h1 : 1'h0; // pull-up when released
endmodule

// File: dv/tb.sv
`timescale 1ns/1ns
// ****
// bench
// ****
module tb;
    import dme_pkg::*;
    logic clock = 1'h0;
    logic reset = 1'h1;
    logic scl_i = 1'h1;
    logic sclk = 1'h0;
    logic tx_drive = 1'h0;
    logic line_s;
    logic we_s;
    logic sda_line;
    logic write_enable;
    logic bidir_mode;
    logic [6:0] mem_addr;
    logic [7:0] mem_rdata;
    dme_pin_t sda_pin;
    int bad_count = 0;
    int n_compared = 0;
    always #10 clock = ~clock;
    dme_top dut_u (.clock(clock), .reset(reset), .clock_en(1'h1), .scl(scl_i), .stream_clk(sclk),
        .sda_level(sda_line), .sda_pin(sda_pin), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .write_enable(write_enable), .bidir_mode(bidir_mode), .bidir_tx_bit(8'h00), .bidir_tx_drive(tx_drive));
    dme_far far_u (.mem_addr(mem_addr), .sda_pin(sda_pin), .mem_rdata(mem_rdata), .sda_line(sda_line));
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one 160 ns stream clock period, line sampled late in the low phase
    task automatic vpulse();
        sclk <= 1'h1;
        repeat (3) @(posedge clock);
        @(negedge clock);
        we_s = write_enable;
        @(posedge clock);
        sclk <= 1'h0;
        repeat (3) @(posedge clock);
        @(negedge clock);
        line_s = sda_line;
        @(posedge clock);
    endtask
    task automatic t_sync();
        for (int i = 0; i < 9; i++)
        begin
            vpulse();
            check("sync", line_s, 1'h1);
        end
        check("mode", bidir_mode, 1'h0);
        check("wen", we_s, 1'h0);
    endtask
    task automatic t_stream();
        logic [7:0] b;
        for (int n = 0; n < 129; n++)
        begin
            b = {1'h0, 7'(n)} ^ 8'h5A;
            for (int i = 8; i >= 0; i--)
            begin
                vpulse();
                check("bit", line_s, (i == 0) ? 1'h1 : b[i - 1]);
            end
        end
    endtask
    task automatic t_bidir();
        scl_i <= 1'h0;
        repeat (12) @(posedge clock);
        vpulse();
        check("mode", bidir_mode, 1'h1);
        check("line", line_s, 1'h1);
        check("wen", we_s, 1'h1);
        scl_i <= 1'h1;
        tx_drive <= 1'h1;
        repeat (30) @(posedge clock);
        scl_i <= 1'h0;
        repeat (9) @(posedge clock);
        tx_drive <= 1'h0;
        repeat (5) @(negedge clock);
        check("held", sda_line, 1'h0);
        repeat (20) @(negedge clock);
        check("freed", sda_line, 1'h1);
        @(posedge clock);
        scl_i <= 1'h1;
        vpulse();
        check("stay", bidir_mode, 1'h1);
    endtask
    // power cycle: only reset brings transmit-only mode back
    task automatic t_repower();
        reset <= 1'h1;
        repeat (3) @(posedge clock);
        reset <= 1'h0;
        @(negedge clock);
        check("repower", bidir_mode, 1'h0);
        check("addr", {1'h0, mem_addr}, 8'h00);
        check("line", sda_line, 1'h1);
    endtask
    initial
    begin
        repeat (20000) @(posedge clock);
        bad_count++;
        tally_and_finish();
    end
    initial
    begin
        repeat (3) @(posedge clock);
        reset <= 1'h0;
        @(posedge clock);
        t_sync();
        t_stream();
        t_bidir();
        t_repower();
        tally_and_finish();
    end
endmodule
